// *** core/hdop_top.sv ***
// headphone/speaker/receiver output protection, pop reduction and headset detection with AXI4-Lite registers
`timescale 1ns/10ps
// How it works
// - short detected: outputs off, short flag set
// - cap-mode short detection off by control bit
// - pop reduction on after reset, bit disables
// - no ground amp: charge 0.8 or 4 s
// - ground amp up: power-up takes 1 ms
// - pop sequence on every headphone power-up
// - speaker short protection only when enabled
// - receiver and headphones never on together
// - headset presence flag follows insert/remove
// - headset interrupt on pin one/two by bits
// - headset detection only when enabled
// - no headset: headphone one, ground, bias off
// - button press updates button flag
// - button interrupt on pin one by field
// - headset interrupt pulse about 1.5 ms
// - headset debounce 16 to 128 ms
// - presence flag holds while headset connected
// - button debounce none, 8, 16, 32 ms
// - button irq: debounce+0.5ms late, press+resolution long
// - button flag clears on read after release
module hdop_top #(
    parameter int POP_SHORT_TICKS = hdop_pkg::POP_SHORT_MS * 2,
    parameter int POP_LONG_TICKS = hdop_pkg::POP_LONG_MS * 2,
    parameter int POP_VG_TICKS = hdop_pkg::POP_VG_MS * 2,
    parameter int TICK_CYCLES = hdop_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog sense inputs
    input wire logic short_hp_in,
    input wire logic short_vg_in,
    input wire logic short_spk_in,
    input wire logic headset_sense_input,
    input wire logic button_sense_in,
    // driver enables
    output hdop_pkg::hdop_drv_t drv_en,
    output logic pop_ramp,
    // interrupt pins
    output logic general_pin_one,
    output logic general_pin_two
);
    logic [15:0] pwr_q, cap_q, prot_q, hset_q, pop_q;
    logic [1:0] btn_cfg_q;
    logic short_q, hs_pres_q, btn_flag_q;
    logic [2:0] s1_q, s2_q;
    logic [1:0] hs_s_q, bt_s_q;
    // axi state
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go, rd_hs_read;
    // tick divider: 0.5 ms enable
    logic [$clog2(TICK_CYCLES+1)-1:0] tdiv_q;
    logic tick;
    always_ff @(posedge aclk) begin
        if (!aresetn || tdiv_q == ($bits(tdiv_q))'(TICK_CYCLES - 1)) begin
            tdiv_q <= '0;
        end else begin
            tdiv_q <= tdiv_q + 1'b1;
        end
    end
    assign tick = (tdiv_q == ($bits(tdiv_q))'(TICK_CYCLES - 1));
    // pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            hs_s_q <= '0;
            bt_s_q <= '0;
        end else begin
            s1_q <= {short_spk_in, short_vg_in, short_hp_in};
            s2_q <= s1_q;
            hs_s_q <= {hs_s_q[0], headset_sense_input};
            bt_s_q <= {bt_s_q[0], button_sense_in};
        end
    end
    // axi write channel
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'h0;
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
        merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction
    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_q <= hdop_pkg::PWR_RESET;
            cap_q <= hdop_pkg::CTRL_RESET;
            prot_q <= hdop_pkg::CTRL_RESET;
            hset_q <= hdop_pkg::CTRL_RESET;
            pop_q <= hdop_pkg::CTRL_RESET;
            btn_cfg_q <= '0;
        end else if (wr_go) begin
            case (awaddr_q)
                hdop_pkg::OFF_PWR_CTRL: pwr_q <= merge(pwr_q, wdata_q, wstrb_q);
                hdop_pkg::OFF_CAP_CTRL: cap_q <= merge(cap_q, wdata_q, wstrb_q);
                hdop_pkg::OFF_PROT_CTRL: prot_q <= merge(prot_q, wdata_q, wstrb_q);
                hdop_pkg::OFF_HSET: hset_q <= merge(hset_q, wdata_q, wstrb_q);
                hdop_pkg::OFF_POP: pop_q <= merge(pop_q, wdata_q, wstrb_q);
                hdop_pkg::OFF_BTN_CFG: if (wstrb_q[0]) btn_cfg_q <= wdata_q[1:0];
                default: ;
            endcase
        end
    end
    // powered-down status per driver (1 = down, includes mic bias)
    logic [5:0] pd_stat;
    logic hs_gate;
    assign hs_gate = hset_q[hdop_pkg::HS_EN_BIT] && !hs_pres_q;
    // driver enables after protection, headset gating and exclusivity
    always_comb begin
        drv_en.hp_one = !pwr_q[hdop_pkg::PD_HP1_BIT] && !short_q && !hs_gate;
        drv_en.hp_two = !pwr_q[hdop_pkg::PD_HP2_BIT] && !short_q;
        drv_en.receiver = !pwr_q[hdop_pkg::PD_RCV_BIT] && !short_q
            && pwr_q[hdop_pkg::PD_HP1_BIT] && pwr_q[hdop_pkg::PD_HP2_BIT];
        drv_en.speaker = !pwr_q[hdop_pkg::PD_SPK_BIT] && !short_q;
        drv_en.vground = !pwr_q[hdop_pkg::PD_VG_BIT] && !short_q && !hs_gate;
        drv_en.mic_bias = !short_q && !hs_gate;
    end
    // short detection
    logic short_hit;
    assign short_hit = (s2_q[0] && !cap_q[hdop_pkg::CAP_SC_DIS_BIT])
        || (s2_q[1] && !prot_q[hdop_pkg::VG_SC_DIS_BIT])
        || (s2_q[2] && prot_q[hdop_pkg::SPK_SC_EN_BIT]);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            short_q <= 1'b0;
        end else if (short_hit) begin
            short_q <= 1'b1;
        end else if ((pwr_q & hdop_pkg::PD_ALL_MASK) == hdop_pkg::PD_ALL_MASK && &pd_stat) begin
            short_q <= 1'b0;
        end
    end
    // pop reduction: ramp counter on each headphone power-up
    logic hp_on_q, ramp_q;
    logic [15:0] pop_cnt_q;
    logic [15:0] pop_len;
    always_comb begin
        if (drv_en.vground) begin
            pop_len = 16'(POP_VG_TICKS);
        end else if (pop_q[hdop_pkg::POP_LONG_BIT]) begin
            pop_len = 16'(POP_LONG_TICKS);
        end else begin
            pop_len = 16'(POP_SHORT_TICKS);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hp_on_q <= 1'b0;
            ramp_q <= 1'b0;
            pop_cnt_q <= '0;
        end else begin
            hp_on_q <= drv_en.hp_one || drv_en.hp_two;
            if ((drv_en.hp_one || drv_en.hp_two) && !hp_on_q && !pop_q[hdop_pkg::POP_DIS_BIT]) begin
                ramp_q <= 1'b1;
                pop_cnt_q <= pop_len;
            end else if (!(drv_en.hp_one || drv_en.hp_two)) begin
                ramp_q <= 1'b0;
            end else if (ramp_q && tick) begin
                if (pop_cnt_q <= 16'h0001) begin
                    ramp_q <= 1'b0;
                end
                pop_cnt_q <= pop_cnt_q - 16'h0001;
            end
        end
    end
    assign pop_ramp = ramp_q;
    assign pd_stat = {!drv_en.mic_bias, !drv_en.vground, !drv_en.speaker,
        !drv_en.receiver, !drv_en.hp_two, !drv_en.hp_one};
    // headset detection debounce: count 8 samples at selected resolution
    logic [1:0] hs_code;
    logic [5:0] hs_div_q;
    logic [5:0] hs_res;
    logic [3:0] hs_run_q;
    logic [3:0] hs_irq_q;
    assign hs_code = hset_q[hdop_pkg::HS_DB_LO +: 2];
    assign hs_res = 6'(4 << hs_code);
    always_ff @(posedge aclk) begin
        if (!aresetn || !hset_q[hdop_pkg::HS_EN_BIT]) begin
            hs_div_q <= '0;
            hs_run_q <= '0;
            hs_pres_q <= 1'b0;
            hs_irq_q <= '0;
        end else if (tick) begin
            hs_div_q <= (hs_div_q + 6'h01 >= hs_res) ? 6'h00 : hs_div_q + 6'h01;
            if (hs_irq_q != 4'h0) begin
                hs_irq_q <= hs_irq_q - 4'h1;
            end
            if (hs_div_q == 6'h00) begin
                if (hs_s_q[1] == hs_pres_q) begin
                    hs_run_q <= '0;
                end else if (hs_run_q == 4'h7) begin
                    hs_run_q <= '0;
                    hs_pres_q <= hs_s_q[1];
                    hs_irq_q <= 4'(hdop_pkg::HS_PULSE_TICKS);
                end else begin
                    hs_run_q <= hs_run_q + 4'h1;
                end
            end
        end
    end
    // button debounce: 8 samples at 1/2/4 ms, or none
    logic [3:0] bt_div_q;
    logic [3:0] bt_res;
    logic [3:0] bt_run_q;
    logic bt_stable_q, bt_irq_q;
    logic [1:0] bt_dly_q;
    assign bt_res = 4'(1 << btn_cfg_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bt_div_q <= '0;
            bt_run_q <= '0;
            bt_stable_q <= 1'b0;
            bt_irq_q <= 1'b0;
            bt_dly_q <= '0;
        end else if (btn_cfg_q == 2'h0) begin
            bt_stable_q <= bt_s_q[1];
            bt_irq_q <= bt_s_q[1];
            bt_run_q <= '0;
            bt_dly_q <= '0;
        end else if (tick) begin
            bt_div_q <= (bt_div_q + 4'h1 >= bt_res) ? 4'h0 : bt_div_q + 4'h1;
            if (bt_dly_q != 2'h0) begin
                bt_dly_q <= bt_dly_q - 2'h1;
                if (bt_dly_q == 2'h1) begin
                    bt_irq_q <= 1'b1;
                end
            end
            if (bt_div_q == 4'h0) begin
                if (bt_s_q[1] == bt_stable_q) begin
                    bt_run_q <= '0;
                    if (!bt_s_q[1]) begin
                        bt_irq_q <= 1'b0;
                    end
                end else if (!bt_s_q[1]) begin
                    bt_stable_q <= 1'b0; // release drops one sample later
                end else if (bt_run_q == 4'h7) begin
                    bt_run_q <= '0;
                    bt_stable_q <= 1'b1;
                    bt_dly_q <= 2'(hdop_pkg::BTN_EXTRA_TICKS);
                end else begin
                    bt_run_q <= bt_run_q + 4'h1;
                end
            end
        end
    end
    // button flag: set on press, cleared by read after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            btn_flag_q <= 1'b0;
        end else if (bt_stable_q) begin
            btn_flag_q <= 1'b1;
        end else if (rd_hs_read) begin
            btn_flag_q <= 1'b0;
        end
    end
    // interrupt pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            general_pin_one <= 1'b0;
            general_pin_two <= 1'b0;
        end else begin
            general_pin_one <= (hset_q[hdop_pkg::HS_IRQ1_BIT] && hs_irq_q != 4'h0)
                || (hset_q[hdop_pkg::BTN_IRQ_LO +: 2] != 2'h0 && bt_irq_q);
            general_pin_two <= hset_q[hdop_pkg::HS_IRQ2_BIT] && hs_irq_q != 4'h0;
        end
    end
    // axi read channel
    logic [15:0] rmux;
    always_comb begin
        rmux = 16'h0000;
        case (s_axi_araddr)
            hdop_pkg::OFF_SHORT_STAT: rmux[hdop_pkg::SHORT_FLAG_BIT] = short_q;
            hdop_pkg::OFF_PWR_CTRL: rmux = pwr_q;
            hdop_pkg::OFF_CAP_CTRL: rmux = cap_q;
            hdop_pkg::OFF_PROT_CTRL: rmux = prot_q;
            hdop_pkg::OFF_HSET: begin
                rmux = hset_q;
                rmux[hdop_pkg::HS_PRES_BIT] = hs_pres_q;
                rmux[hdop_pkg::BTN_FLAG_BIT] = btn_flag_q;
            end
            hdop_pkg::OFF_POP: rmux = {pd_stat, pop_q[9:0]};
            hdop_pkg::OFF_BTN_CFG: rmux = {14'h0000, btn_cfg_q};
            hdop_pkg::OFF_DRV_IN: rmux = {9'h000, ramp_q, drv_en};
            default: rmux = 16'h0000;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_hs_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == hdop_pkg::OFF_HSET && !bt_stable_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rmux};
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** include/hdop_pkg.sv ***
// package: register map, field positions, reset values and timing for the output protect block
package hdop_pkg;
    // byte offsets on the register bus (printed offsets are multiples of four)
    localparam logic [7:0] OFF_SHORT_STAT = 8'h1d;
    localparam logic [7:0] OFF_PWR_CTRL = 8'h05;
    localparam logic [7:0] OFF_CAP_CTRL = 8'h20;
    localparam logic [7:0] OFF_PROT_CTRL = 8'h21;
    localparam logic [7:0] OFF_HSET = 8'h22;
    localparam logic [7:0] OFF_POP = 8'h25;
    localparam logic [7:0] OFF_BTN_CFG = 8'h40;
    localparam logic [7:0] OFF_DRV_IN = 8'h44;
    // field positions
    localparam int SHORT_FLAG_BIT = 1;
    localparam int CAP_SC_DIS_BIT = 0;
    localparam int VG_SC_DIS_BIT = 4;
    localparam int SPK_SC_EN_BIT = 5;
    localparam int HS_EN_BIT = 15;
    localparam int HS_PRES_BIT = 12;
    localparam int BTN_FLAG_BIT = 11;
    localparam int HS_DB_LO = 9;
    localparam int HS_IRQ1_BIT = 3;
    localparam int HS_IRQ2_BIT = 4;
    localparam int BTN_IRQ_LO = 0;
    localparam int POP_DIS_BIT = 5;
    localparam int POP_LONG_BIT = 4;
    localparam int PD_STAT_LO = 10;
    // power-down control bits in the power register
    localparam logic [15:0] PWR_RESET = 16'h0000;
    localparam logic [15:0] PD_ALL_MASK = 16'h19c0;
    localparam int PD_HP1_BIT = 6;
    localparam int PD_HP2_BIT = 7;
    localparam int PD_RCV_BIT = 8;
    localparam int PD_SPK_BIT = 11;
    localparam int PD_VG_BIT = 12;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 500;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int POP_SHORT_MS = 800;
    localparam int POP_LONG_MS = 4000;
    localparam int POP_VG_MS = 1;
    localparam int HS_PULSE_US = 1750;
    localparam int HS_PULSE_TICKS = HS_PULSE_US / TICK_US;
    localparam int BTN_EXTRA_US = 500;
    localparam int BTN_EXTRA_TICKS = BTN_EXTRA_US / TICK_US;
    // driver state carrier
    typedef struct packed {
        logic hp_one;
        logic hp_two;
        logic receiver;
        logic speaker;
        logic vground;
        logic mic_bias;
    } hdop_drv_t;
endpackage

// *** testbench/hdop_chk_asserts.sv ***
// concurrent checks on the ports of the output protect block
`timescale 1ns/10ps
module hdop_chk #(
    parameter int TICK_CYCLES = 10,
    parameter int POP_LONG_TICKS = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // driver and interrupt outputs
    input wire hdop_pkg::hdop_drv_t drv_en,
    input wire logic pop_ramp,
    input wire logic general_pin_two
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    int pin2_q;
    int ramp_q;
    // high-time counters for the pulse and the ramp
    always_ff @(posedge aclk) begin
        pin2_q <= (!aresetn || !general_pin_two) ? 0 : pin2_q + 1;
        ramp_q <= (!aresetn || !pop_ramp) ? 0 : ramp_q + 1;
    end
    a_rcv_hp_excl: assert property (!(drv_en.receiver && (drv_en.hp_one || drv_en.hp_two)))
        else $error("receiver and headphone on together");
    a_hs_pulse_len: assert property ($fell(general_pin_two) |->
        pin2_q > (hdop_pkg::HS_PULSE_TICKS - 1) * TICK_CYCLES && pin2_q <= hdop_pkg::HS_PULSE_TICKS * TICK_CYCLES)
        else $error("headset pulse length off");
    a_ramp_bound: assert property (pop_ramp |-> ramp_q < (POP_LONG_TICKS + 1) * TICK_CYCLES)
        else $error("ramp runs too long");
    a_ramp_hp_on: assert property ($rose(pop_ramp) |-> drv_en.hp_one || drv_en.hp_two)
        else $error("ramp without headphone on");
    a_b_after_wr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_r_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_resp_okay: assert property ((!s_axi_bvalid || s_axi_bresp == 2'h0) && (!s_axi_rvalid || s_axi_rresp == 2'h0))
        else $error("response not okay");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule
bind hdop_top hdop_chk #(.TICK_CYCLES(TICK_CYCLES), .POP_LONG_TICKS(POP_LONG_TICKS)) u_chk (.*);

// *** testbench/hdop_jack.sv ***
// headset jack and output load model that drives the sense lines
`timescale 1ns/10ps
module hdop_jack (
    // clock
    input wire logic aclk,
    // sense lines, high means present, pressed or shorted
    output logic headset_sense_input,
    output logic button_sense_in,
    output logic short_hp_in,
    output logic short_vg_in,
    output logic short_spk_in
);
    initial begin
        headset_sense_input = 1'b0;
        {button_sense_in, short_hp_in, short_vg_in, short_spk_in} = 4'h0;
    end
    // levels as {button, headphone short, ground amp short, speaker short}
    task automatic lvl(input logic [3:0] s);
        @(posedge aclk);
        {button_sense_in, short_hp_in, short_vg_in, short_spk_in} <= s;
    endtask
    // plug contacts chatter before they settle
    task automatic plug(input logic v);
        repeat (3) begin
            @(posedge aclk);
            headset_sense_input <= v;
            repeat (4) @(posedge aclk);
            headset_sense_input <= !v;
        end
        @(posedge aclk);
        headset_sense_input <= v;
    endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the output protect block
`timescale 1ns/10ps
module tb;
    localparam int TC = 10;
    localparam logic [7:0] PW = hdop_pkg::OFF_PWR_CTRL;
    localparam logic [7:0] HS = hdop_pkg::OFF_HSET;
    localparam logic [7:0] SS = hdop_pkg::OFF_SHORT_STAT;
    localparam logic [7:0] PP = hdop_pkg::OFF_POP;
    localparam logic [7:0] PR = hdop_pkg::OFF_PROT_CTRL;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pop_ramp, general_pin_one, general_pin_two;
    logic headset_sense_input, button_sense_in, short_hp_in, short_vg_in, short_spk_in, mon_on, p2_q;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, note;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    hdop_pkg::hdop_drv_t drv_en;
    int bad_count, n_checks, cyc, rlen;
    logic [31:0] rq[$];
    int pq[$];
    logic pn[$];
    hdop_top #(.POP_SHORT_TICKS(4), .POP_LONG_TICKS(8), .POP_VG_TICKS(2), .TICK_CYCLES(TC)) uut (.*);
    hdop_jack j (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic w(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // upper data bits are noise the block must ignore; the strobe picks the bytes
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'($urandom()), d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // the note holds {mask, expected}
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        rq.push_back({m, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // output watcher: takes the oldest note whenever a result shows
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
        p2_q <= general_pin_two;
        rlen <= pop_ramp ? rlen + 1 : 0;
        if (s_axi_rvalid && s_axi_rready) begin
            note = rq.pop_front();
            chk("rdata", note[15:0], s_axi_rdata[15:0] & note[31:16]);
        end
        if (mon_on && !pop_ramp && rlen > 0) chk("ramp ticks", 16'(pq.pop_front()), 16'((rlen + TC - 1) / TC));
        if (mon_on && general_pin_two && !p2_q) chk("pin one", 16'(pn.pop_front()), 16'(general_pin_one));
    end
    initial begin
        logic [15:0] rv;
        logic [3:0] st;
        logic [1:0] bc;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, mon_on, p2_q} = 5'h00;
        {s_axi_bready, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h0;
        w(10);
        aresetn <= 1'b1;
        void'($urandom(77));
        rd(PW, 16'hffff, 16'h0000);
        rd(HS, 16'hffff, 16'h0000);
        rd(SS, 16'h0002, 16'h0000);
        rd(8'h80, 16'hffff, 16'h0000);
        w(40);
        mon_on <= 1'b1;
        $display("test reset done");
        wr(PW, 16'h00c0);
        chk("drive", 16'h0008, 16'(drv_en) & 16'h0038);
        pq.push_back(2);
        wr(PW, 16'h0000);
        chk("receiver", 16'h0000, 16'(drv_en.receiver));
        w(60);
        wr(PW, 16'h10c0);
        pq.push_back(4);
        wr(PW, 16'h1000);
        w(100);
        wr(PP, 16'h0010);
        wr(PW, 16'h10c0);
        pq.push_back(8);
        wr(PW, 16'h1000);
        w(120);
        wr(PP, 16'h0020);
        wr(PW, 16'h00c0);
        wr(PW, 16'h0000);
        w(100);
        wr(PP, 16'h0000);
        $display("test pop done");
        j.lvl(4'b0001);
        w(20);
        rd(SS, 16'h0002, 16'h0000);
        j.lvl(4'b0000);
        wr(hdop_pkg::OFF_CAP_CTRL, 16'h0001);
        j.lvl(4'b0100);
        w(20);
        rd(SS, 16'h0002, 16'h0000);
        j.lvl(4'b0000);
        wr(hdop_pkg::OFF_CAP_CTRL, 16'h0000);
        wr(PR, 16'h0010);
        j.lvl(4'b0010);
        w(20);
        rd(SS, 16'h0002, 16'h0000);
        j.lvl(4'b0000);
        wr(PR, 16'h0020);
        j.lvl(4'b0001);
        w(20);
        chk("all off", 16'h0000, 16'(drv_en));
        rd(SS, 16'h0002, 16'h0002);
        j.lvl(4'b0000);
        wr(PW, hdop_pkg::PD_ALL_MASK);
        w(20);
        rd(PP, 16'h7c00, 16'h7c00);
        rd(SS, 16'h0002, 16'h0000);
        wr(PW, 16'h00c0);
        pq.push_back(2);
        wr(PW, 16'h0000);
        w(60);
        $display("test short done");
        j.plug(1'b1);
        w(400);
        rd(HS, 16'h1000, 16'h0000);
        j.plug(1'b0);
        w(400);
        wr(HS, 16'h8018);
        chk("forced off", 16'h0000, 16'(drv_en) & 16'h0023);
        pn.push_back(1'b1);
        j.plug(1'b1);
        w(200);
        rd(HS, 16'h1000, 16'h0000);
        w(500);
        rd(HS, 16'h1000, 16'h1000);
        chk("hp one", 16'h0020, 16'(drv_en) & 16'h0020);
        pn.push_back(1'b1);
        j.plug(1'b0);
        w(700);
        rd(HS, 16'h1000, 16'h0000);
        wr(HS, 16'h8010);
        pn.push_back(1'b0);
        j.plug(1'b1);
        w(700);
        rd(HS, 16'h1000, 16'h1000);
        $display("test headset done");
        // button interrupt routed to pin one from here on
        wr(HS, 16'h8011);
        for (int c = 0; c < 2; c++) begin
            wr(hdop_pkg::OFF_BTN_CFG, 16'(c));
            j.lvl(4'b1000);
            w(20);
            rd(HS, 16'h0800, c ? 16'h0000 : 16'h0800);
            chk("pin one", c ? 16'h0000 : 16'h0001, 16'(general_pin_one));
            w(400);
            rd(HS, 16'h0800, 16'h0800);
            chk("pin one", 16'h0001, 16'(general_pin_one));
            j.lvl(4'b0000);
            w(400);
            chk("pin one", 16'h0000, 16'(general_pin_one));
            rd(HS, 16'h0800, 16'h0800);
            rd(HS, 16'h0800, 16'h0000);
        end
        bc = 2'h1;
        repeat (3) begin
            rv = 16'($urandom());
            st = 4'($urandom());
            if (st[0]) bc = rv[1:0];
            wr(hdop_pkg::OFF_BTN_CFG, rv, st);
            rd(hdop_pkg::OFF_BTN_CFG, 16'h0003, {14'h0000, bc});
        end
        $display("test button done");
        w(5);
        chk("pending notes", 16'h0000, 16'(rq.size() + pq.size() + pn.size()));
        close_out();
    end
endmodule
